// [core/bif_channel.sv]
// Purpose: One binary input channel: debounce, polarity, blocking, sequence level, multi press.
// Assumes: Avalon-MM slave with byte addresses; one wait state on every access.
// Notes:   One transmit strobe per cycle; a cyclic send waits while another send is pending.

// Behaviour
// [RULE1] Up to five sequence level outputs, count configurable
// [RULE2] Step command: one up, zero down
// [RULE3] Current sequence level held as byte
// [RULE4] Optional one-bit blocking input disables channel
// [RULE5] Blocked and cyclic: keep sending last state
// [RULE6] Blocking detaches terminals, sending continues
// [RULE7] Blocking does not affect manual operation
// [RULE8] Debounce selectable 10 to 150 ms
// [RULE9] Act on edge at once, start debounce
// [RULE10] Ignore edges during debounce interval
// [RULE11] Polarity: closed or opened means actuated
// [RULE12] Screening setting slows evaluation for long cables
// [RULE13] Multi press sends value for press count
// [RULE14] Gap timer restarts per press, expiry sends
// [RULE15] Press count saturates at configured maximum one-four
// [RULE16] Long press discards earlier short presses
// [RULE17] Toggle option inverts object value each send
// [RULE18] Millisecond tick prescaler, input synchronised first
module bif_channel #(
  parameter int TICK_CYCLES = bif_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Contact and local operation
  input  wire logic        contact_in,
  input  wire logic        manual_en,
  input  wire logic        manual_act,
  // Messages towards the bus layer
  output logic             tx_stb,
  output logic [3:0]       tx_obj,
  output logic             tx_val,
  output logic [7:0]       level_byte,
  output logic [4:0]       level_bits,
  output logic             actuated
);
  logic [31:0] ctrl;
  logic [31:0] cfg;
  logic [31:0] tmr;
  logic [15:0] cyc;
  logic        block_val;
  logic [31:0] next_ctrl;
  logic [31:0] next_cfg;
  logic [31:0] next_tmr;
  logic [15:0] next_cyc;
  logic        next_block;
  logic [31:0] next_rdata;
  logic        next_wait;
  logic        acc;
  logic        wr_go;
  logic        step_go;
  logic        blocked;
  logic [2:0]  cnt;
  logic [3:0]  fold_val;
  logic        long_val;
  bif_pkg::bif_mstate_t mstate;

  // Bus: request seen with waitrequest high, answered one cycle later
  always_comb begin
    next_ctrl  = ctrl;
    next_cfg   = cfg;
    next_tmr   = tmr;
    next_cyc   = cyc;
    next_block = block_val;
    next_wait  = 1'b1;
    next_rdata = avs_readdata;
    acc        = (avs_read || avs_write) && avs_waitrequest;
    wr_go      = avs_write && !avs_waitrequest;
    step_go    = 1'b0;
    if (acc) begin
      next_wait = 1'b0;
      unique case (avs_address)
        bif_pkg::REG_CTRL:   next_rdata = ctrl;
        bif_pkg::REG_CFG:    next_rdata = cfg;
        bif_pkg::REG_TIME:   next_rdata = tmr;
        bif_pkg::REG_CMD:    next_rdata = {31'h0000_0000, block_val};
        bif_pkg::REG_STATUS: next_rdata = {10'h000, mstate, cnt, 6'h00, blocked, actuated, level_byte};
        bif_pkg::REG_OUTS:   next_rdata = {19'h0_0000, long_val, fold_val, 3'h0, level_bits};
        bif_pkg::REG_CYC:    next_rdata = {16'h0000, cyc};
        default:             next_rdata = 32'h0000_0000;
      endcase
    end
    if (wr_go) begin
      unique case (avs_address)
        bif_pkg::REG_CTRL: next_ctrl = avs_writedata;
        bif_pkg::REG_CFG:  next_cfg  = avs_writedata;
        bif_pkg::REG_TIME: next_tmr  = avs_writedata;
        bif_pkg::REG_CYC:  next_cyc  = avs_writedata[15:0];
        bif_pkg::REG_CMD: begin
          next_block = avs_writedata[bif_pkg::CMD_BLOCK];
          step_go    = avs_writedata[bif_pkg::CMD_STEP_GO];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl            <= bif_pkg::CTRL_RST;
      cfg             <= bif_pkg::CFG_RST;
      tmr             <= bif_pkg::TIME_RST;
      cyc             <= bif_pkg::CYC_RST;
      block_val       <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      ctrl            <= next_ctrl;
      cfg             <= next_cfg;
      tmr             <= next_tmr;
      cyc             <= next_cyc;
      block_val       <= next_block;
      avs_waitrequest <= next_wait;
      avs_readdata    <= next_rdata;
    end
  end

  // Settings
  logic [2:0]  deb_sel;
  logic [7:0]  dead_ms;
  logic [2:0]  max_ops;
  logic [2:0]  lvl_cnt;
  logic [1:0]  fold_sel;
  logic [1:0]  long_sel;
  assign deb_sel  = cfg[bif_pkg::CFG_DEB_LSB +: 3];
  assign dead_ms  = bif_pkg::DEB_MS[(deb_sel > 3'h6) ? 3'h6 : deb_sel]; // [RULE8]
  assign max_ops  = {1'b0, cfg[bif_pkg::CFG_MAXOP_LSB +: 2]} + 3'h1; // [RULE15]
  assign lvl_cnt  = (cfg[bif_pkg::CFG_LVL_LSB +: 3] > 3'h5) ? 3'h5 : cfg[bif_pkg::CFG_LVL_LSB +: 3]; // [RULE1]
  assign fold_sel = cfg[bif_pkg::CFG_FOLDV_LSB +: 2];
  assign long_sel = cfg[bif_pkg::CFG_LONGV_LSB +: 2];
  assign blocked  = ctrl[bif_pkg::CTRL_BLOCK_EN] && block_val; // [RULE4]

  // Millisecond prescaler
  logic [15:0] pre_cnt;
  logic        tick_ms;
  assign tick_ms = (pre_cnt == 16'(TICK_CYCLES - 1));
  always_ff @(posedge clk_sys) begin
    if (rst) pre_cnt <= 16'h0000;
    else     pre_cnt <= tick_ms ? 16'h0000 : pre_cnt + 16'h0001; // [RULE18]
  end

  logic deb_level;
  logic deb_edge;
  bif_debounce u_deb (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .tick_ms    (tick_ms),
    .raw_in     (contact_in),
    .dead_ms    (dead_ms),
    .settle_ms  (cfg[bif_pkg::CFG_SCR_LSB +: 2]),
    .level      (deb_level),
    .edge_pulse (deb_edge)
  );

  // Actuation source; manual path bypasses blocking
  logic manual_q;
  logic phys_act;
  logic src_act;
  logic src_edge;
  assign phys_act = deb_level ^ ctrl[bif_pkg::CTRL_POL_OPEN]; // [RULE11]
  assign src_act  = manual_en ? manual_act : phys_act;
  assign src_edge = manual_en ? (manual_act != manual_q) : (deb_edge && !blocked); // [RULE6] [RULE7]

  // Multi press machine
  bif_pkg::bif_mstate_t next_mstate;
  logic [2:0]  next_cnt;
  logic [15:0] ms_cnt;
  logic [15:0] next_ms;
  logic        is_long;
  logic        next_long;
  logic [3:0]  next_fold;
  logic        next_lval;
  logic        next_act;
  logic        next_stb;
  logic [3:0]  next_obj;
  logic        next_tval;
  logic        cyc_pend;
  logic        next_cpend;
  logic [15:0] cyc_cnt;
  logic [15:0] next_ccnt;
  logic        cyc_fire;
  logic        press;
  logic        release_e;
  logic        multi;

  function automatic logic pick(input logic [1:0] sel, input logic cur);
    pick = (sel == bif_pkg::VAL_ON) ? 1'b1 : (sel == bif_pkg::VAL_OFF) ? 1'b0 : !cur; // [RULE17]
  endfunction

  always_comb begin
    multi       = ctrl[bif_pkg::CTRL_MULTI];
    press       = src_edge && src_act;
    release_e   = src_edge && !src_act;
    next_mstate = mstate;
    next_cnt    = cnt;
    next_ms     = tick_ms ? ms_cnt + 16'h0001 : ms_cnt;
    next_long   = is_long;
    next_fold   = fold_val;
    next_lval   = long_val;
    next_act    = src_edge ? src_act : actuated;
    next_stb    = 1'b0;
    next_obj    = tx_obj;
    next_tval   = tx_val;
    cyc_fire    = ctrl[bif_pkg::CTRL_CYC_EN] && tick_ms && (cyc_cnt + 16'h0001 >= cyc);
    next_ccnt   = cyc_fire ? 16'h0000 : (tick_ms ? cyc_cnt + 16'h0001 : cyc_cnt);
    next_cpend  = cyc_pend || cyc_fire;
    if (!multi) begin
      next_mstate = bif_pkg::MS_IDLE;
      next_cnt    = 3'h0;
      if (src_edge) begin
        next_stb  = 1'b1; // [RULE9]
        next_obj  = bif_pkg::OBJ_STATE;
        next_tval = src_act;
      end
    end else begin
      unique case (mstate)
        bif_pkg::MS_IDLE, bif_pkg::MS_GAP: begin
          if (press) begin
            next_mstate = bif_pkg::MS_PRESS;
            next_cnt    = (cnt >= max_ops) ? max_ops : cnt + 3'h1; // [RULE15]
            next_ms     = 16'h0000;
            next_long   = 1'b0;
            if (ctrl[bif_pkg::CTRL_EVERY]) begin
              next_stb  = 1'b1;
              next_obj  = {1'b0, next_cnt};
              next_tval = pick(fold_sel, fold_val[next_cnt[1:0] - 2'h1]);
              next_fold[next_cnt[1:0] - 2'h1] = next_tval;
            end
          end else if (mstate == bif_pkg::MS_GAP && tick_ms && ms_cnt + 16'h0001 >= tmr[15:0]) begin
            next_mstate = bif_pkg::MS_IDLE; // [RULE14]
            next_cnt    = 3'h0;
            if (!ctrl[bif_pkg::CTRL_EVERY]) begin
              next_stb  = 1'b1; // [RULE13]
              next_obj  = {1'b0, cnt};
              next_tval = pick(fold_sel, fold_val[cnt[1:0] - 2'h1]);
              next_fold[cnt[1:0] - 2'h1] = next_tval;
            end
          end
        end
        bif_pkg::MS_PRESS: begin
          if (ctrl[bif_pkg::CTRL_LONG_EN] && ms_cnt >= tmr[31:16]) next_long = 1'b1;
          if (release_e) begin
            next_ms = 16'h0000; // [RULE14]
            if (next_long) begin
              next_mstate = bif_pkg::MS_IDLE; // [RULE16]
              next_cnt    = 3'h0;
              next_stb    = 1'b1;
              next_obj    = bif_pkg::OBJ_LONG;
              next_tval   = pick(long_sel, long_val);
              next_lval   = next_tval;
            end else begin
              next_mstate = bif_pkg::MS_GAP;
            end
          end
        end
        default: next_mstate = bif_pkg::MS_IDLE;
      endcase
    end
    // Cyclic send of the held state, also while blocked
    if (!next_stb && cyc_pend) begin
      next_stb   = 1'b1; // [RULE5]
      next_obj   = bif_pkg::OBJ_STATE;
      next_tval  = actuated;
      next_cpend = cyc_fire;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mstate   <= bif_pkg::MS_IDLE;
      cnt      <= 3'h0;
      ms_cnt   <= 16'h0000;
      is_long  <= 1'b0;
      fold_val <= 4'h0;
      long_val <= 1'b0;
      actuated <= 1'b0;
      tx_stb   <= 1'b0;
      tx_obj   <= 4'h0;
      tx_val   <= 1'b0;
      cyc_pend <= 1'b0;
      cyc_cnt  <= 16'h0000;
      manual_q <= 1'b0;
    end else begin
      mstate   <= next_mstate;
      cnt      <= next_cnt;
      ms_cnt   <= next_ms;
      is_long  <= next_long;
      fold_val <= next_fold;
      long_val <= next_lval;
      actuated <= next_act; // [RULE6]
      tx_stb   <= next_stb;
      tx_obj   <= next_obj;
      tx_val   <= next_tval;
      cyc_pend <= next_cpend;
      cyc_cnt  <= next_ccnt;
      manual_q <= manual_act;
    end
  end

  // Switching sequence level
  logic [7:0] next_lvl;
  logic [4:0] next_bits;
  always_comb begin
    next_lvl = level_byte;
    if (step_go) begin
      if (avs_writedata[bif_pkg::CMD_STEP_VAL] && level_byte < {5'h00, lvl_cnt})
        next_lvl = level_byte + 8'h01; // [RULE2]
      else if (!avs_writedata[bif_pkg::CMD_STEP_VAL] && level_byte != 8'h00)
        next_lvl = level_byte - 8'h01;
    end
    if (next_lvl > {5'h00, lvl_cnt}) next_lvl = {5'h00, lvl_cnt};
    for (int i = 0; i < bif_pkg::LEVELS_MAX; i++) begin
      next_bits[i] = (next_lvl > 8'(i)) && (lvl_cnt > 3'(i)); // [RULE1]
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      level_byte <= 8'h00;
      level_bits <= 5'h00;
    end else begin
      level_byte <= next_lvl; // [RULE3]
      level_bits <= next_bits;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_level_in_range: assert property (level_byte <= {5'h00, lvl_cnt} || $changed(cfg)) // [RULE1]
    else $error("Level above configured count");
  a_step_up_one: assert property (step_go && avs_writedata[1] && level_byte < {5'h00, lvl_cnt}
    |=> level_byte == $past(level_byte) + 8'h01) // [RULE2]
    else $error("Step up did not add one");
  a_level_hold: assert property (!step_go && $stable(cfg) |=> $stable(level_byte)) // [RULE3]
    else $error("Level moved without command");
  a_block_freeze: assert property (blocked && !manual_en && !$past(manual_en) |=> $stable(actuated)) // [RULE6]
    else $error("Blocked input changed state");
  a_manual_passes: assert property (manual_en && manual_act != manual_q |=> actuated == $past(manual_act)) // [RULE7]
    else $error("Manual operation lost");
  a_cyclic_sends: assert property (cyc_pend |-> ##[1:2] tx_stb && tx_obj == bif_pkg::OBJ_STATE) // [RULE5]
    else $error("Cyclic send missing");
  a_count_sat: assert property (cnt <= max_ops || $changed(cfg)) // [RULE15]
    else $error("Press count above maximum");
  a_long_clears: assert property (multi && mstate == bif_pkg::MS_PRESS && release_e && next_long
    |=> cnt == 3'h0 && tx_obj == bif_pkg::OBJ_LONG) // [RULE16]
    else $error("Long press kept short count");
  a_gap_sends: assert property (multi && !ctrl[bif_pkg::CTRL_EVERY] && mstate == bif_pkg::MS_GAP
    && !press && tick_ms && ms_cnt + 16'h0001 >= tmr[15:0] |=> tx_stb && tx_obj == {1'b0, $past(cnt)}) // [RULE14]
    else $error("Gap expiry did not send");
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus answer late");
  c_multi_send: cover property (tx_stb && tx_obj == 4'h3);
  c_long_send: cover property (tx_stb && tx_obj == bif_pkg::OBJ_LONG);
  c_blocked_cyc: cover property (blocked && tx_stb && tx_obj == bif_pkg::OBJ_STATE);
  c_level_top: cover property (level_byte == 8'h05);
endmodule

// [shared/bif_pkg.sv]
// Purpose: Constants shared by the binary input channel front end.
// Assumes: 25 MHz system clock, byte addresses on the register bus.
// Notes:   Field positions are bit offsets inside 32-bit registers.
package bif_pkg;
  // Register byte offsets
  localparam logic [4:0]  REG_CTRL    = 5'h00;
  localparam logic [4:0]  REG_CFG     = 5'h04;
  localparam logic [4:0]  REG_TIME    = 5'h08;
  localparam logic [4:0]  REG_CMD     = 5'h0C;
  localparam logic [4:0]  REG_STATUS  = 5'h10;
  localparam logic [4:0]  REG_OUTS    = 5'h14;
  localparam logic [4:0]  REG_CYC     = 5'h18;
  // CTRL bits
  localparam int          CTRL_BLOCK_EN = 0;
  localparam int          CTRL_POL_OPEN = 1;
  localparam int          CTRL_MULTI    = 2;
  localparam int          CTRL_EVERY    = 3;
  localparam int          CTRL_LONG_EN  = 4;
  localparam int          CTRL_CYC_EN   = 5;
  // CFG fields (lsb positions)
  localparam int          CFG_DEB_LSB   = 0;
  localparam int          CFG_SCR_LSB   = 4;
  localparam int          CFG_MAXOP_LSB = 8;
  localparam int          CFG_LVL_LSB   = 12;
  localparam int          CFG_FOLDV_LSB = 16;
  localparam int          CFG_LONGV_LSB = 18;
  // CMD bits
  localparam int          CMD_BLOCK     = 0;
  localparam int          CMD_STEP_VAL  = 1;
  localparam int          CMD_STEP_GO   = 2;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST  = 32'h000A_5203;
  localparam logic [31:0] TIME_RST = 32'h0258_01F4;
  localparam logic [15:0] CYC_RST  = 16'h03E8;
  // Sent value selections
  localparam logic [1:0]  VAL_ON  = 2'h0;
  localparam logic [1:0]  VAL_OFF = 2'h1;
  localparam logic [1:0]  VAL_TOG = 2'h2;
  // Object codes on the transmit strobe
  localparam logic [3:0]  OBJ_STATE = 4'h0;
  localparam logic [3:0]  OBJ_LONG  = 4'h5;
  localparam int          LEVELS_MAX = 5;
  localparam int          FOLD_MAX   = 4;
  // Debounce choices in ms, index 0..6
  localparam logic [6:0][7:0] DEB_MS = {8'h96, 8'h64, 8'h46, 8'h32, 8'h1E, 8'h14, 8'h0A};
  // Millisecond tick
  localparam int          CLK_NS      = 40;
  localparam int          TICK_NS     = 1000000;
  localparam int          TICK_CYCLES = TICK_NS / CLK_NS;
  typedef enum logic [2:0] {
    MS_IDLE  = 3'b001,
    MS_PRESS = 3'b010,
    MS_GAP   = 3'b100
  } bif_mstate_t;
endpackage

// [core/bif_debounce.sv]
// Purpose: Input synchroniser, screening filter and debounce dead time.
// Assumes: tick_ms is a one-cycle pulse every millisecond.
// Notes:   Dead time counts whole ticks, so it may end up to 1 ms early.
module bif_debounce (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       tick_ms,
  // Contact and settings
  input  wire logic       raw_in,
  input  wire logic [7:0] dead_ms,
  input  wire logic [1:0] settle_ms,
  // Filtered result
  output logic            level,
  output logic            edge_pulse
);
  logic       sync1;
  logic       sync2;
  logic [7:0] dead_cnt;
  logic [1:0] settle_cnt;
  logic       next_level;
  logic       next_edge;
  logic [7:0] next_dead;
  logic [1:0] next_settle;

  always_comb begin
    next_level  = level;
    next_edge   = 1'b0;
    next_dead   = dead_cnt;
    next_settle = settle_cnt;
    if (dead_cnt != 8'h00) begin
      // Input not looked at during dead time
      if (tick_ms) next_dead = dead_cnt - 8'h01; // [RULE10]
      next_settle = 2'h0;
    end else if (sync2 == level) begin
      next_settle = 2'h0;
    end else if (settle_cnt >= settle_ms) begin
      // Act at once and start dead time together
      next_level  = sync2; // [RULE9]
      next_edge   = 1'b1;
      next_dead   = dead_ms;
      next_settle = 2'h0;
    end else if (tick_ms) begin
      // Longer screening trades speed for noise immunity
      next_settle = settle_cnt + 2'h1; // [RULE12]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1      <= 1'b0;
      sync2      <= 1'b0;
      level      <= 1'b0;
      edge_pulse <= 1'b0;
      dead_cnt   <= 8'h00;
      settle_cnt <= 2'h0;
    end else begin
      sync1      <= raw_in; // [RULE18]
      sync2      <= sync1;
      level      <= next_level;
      edge_pulse <= next_edge;
      dead_cnt   <= next_dead;
      settle_cnt <= next_settle;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_dead_no_edge: assert property (dead_cnt != 8'h00 |=> !edge_pulse) // [RULE10]
    else $error("Edge accepted during dead time");
  a_edge_starts_dead: assert property (edge_pulse |-> dead_cnt == $past(dead_ms)) // [RULE9]
    else $error("Dead time not started on edge");
  c_edge_seen: cover property (edge_pulse);
endmodule

// [verification/bif_contact_model.sv]
// Purpose: Push button at the input terminals, with contact bounce on every change.
// Assumes: Bounce stays well inside the shortest dead time of 10 ms.
// Notes:   The contact always settles on the requested level.
module bif_contact_model (
  // Clock
  input  wire logic clk_sys,
  // Requested contact state, 1 = closed
  input  wire logic closed_req,
  // Terminal level seen by the channel
  output logic      contact_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       held = 1'b0;
  logic [5:0] bounce_cnt = 6'h00;
  always @(posedge clk_sys) begin
    if (closed_req != held) begin
      held       <= closed_req;
      bounce_cnt <= 6'h28;
    end else if (bounce_cnt != 6'h00) begin
      bounce_cnt <= bounce_cnt - 6'h01;
    end
  end
  // Chatter after the first edge; the channel must ignore it
  assign contact_in = (bounce_cnt != 6'h00 && bounce_cnt[2]) ? ~held : held;
endmodule

// [verification/bif_channel_bench.sv]
// Purpose: Self-checking bench for one binary input channel.
// Assumes: Tick shortened to 20 clocks, so 1 ms is 20 cycles.
// Notes:   Sends are checked against a queue of expected object and value.
module bif_channel_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 20;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        contact_in;
  logic        closed_req = 1'b0;
  logic        manual_en = 1'b0;
  logic        manual_act = 1'b0;
  logic        tx_stb, tx_val, actuated, last_val;
  logic [3:0]  tx_obj;
  logic [7:0]  level_byte;
  logic [4:0]  level_bits;
  logic [4:0]  q[$];
  logic [4:0]  e;
  logic [4:0]  ex;
  logic [31:0] rd;
  int          failures = 0, cmp_count = 0, cyc_cnt = 0, clk_cnt = 0, lvl;
  bit          strict = 1'b1;
  always #20 clk_sys = ~clk_sys;
  bif_contact_model btn_u (.clk_sys(clk_sys), .closed_req(closed_req), .contact_in(contact_in));
  bif_channel #(.TICK_CYCLES(TK)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .contact_in(contact_in), .manual_en(manual_en),
    .manual_act(manual_act), .tx_stb(tx_stb), .tx_obj(tx_obj), .tx_val(tx_val),
    .level_byte(level_byte), .level_bits(level_bits), .actuated(actuated));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d failures", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wait_ms(input int n);
    repeat (n * TK) @(posedge clk_sys);
  endtask
  // Config changes may send on their own; those sends are not judged
  task automatic cfg_wr(input logic [4:0] a, input logic [31:0] d);
    strict = 1'b0;
    bus(1'b1, a, d);
    wait_ms(15);
    q.delete();
    strict = 1'b1;
  endtask
  task automatic press(input logic c, input logic snd, input logic [3:0] obj, input logic v);
    if (snd) q.push_back({obj, v});
    @(posedge clk_sys);
    closed_req <= c;
    wait_ms(15);
  endtask
  always @(posedge clk_sys) begin
    clk_cnt++;
    if (clk_cnt == 60000) begin
      failures++;
      end_of_test();
    end
  end
  always @(posedge clk_sys) begin
    if (!rst && tx_stb === 1'b1) begin
      cyc_cnt++;
      last_val = tx_val;
      if (q.size() != 0) begin
        ex = q.pop_front();
        check("tx_obj", 32'(tx_obj), 32'(ex[4:1]));
        check("tx_val", 32'(tx_val), 32'(ex[0]));
      end else if (strict) begin
        check("unexpected send", 1, 0);
      end
    end
  end
  initial begin
    void'($urandom(32'h7cf4));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check("waitrequest idle", 32'(avs_waitrequest), 1);
    bus(1'b0, bif_pkg::REG_CTRL, 0); check("CTRL", rd, bif_pkg::CTRL_RST);
    bus(1'b0, bif_pkg::REG_CFG, 0); check("CFG", rd, bif_pkg::CFG_RST);
    bus(1'b0, bif_pkg::REG_TIME, 0); check("TIME", rd, bif_pkg::TIME_RST);
    bus(1'b0, bif_pkg::REG_CYC, 0); check("CYC", rd, 32'(bif_pkg::CYC_RST));
    bus(1'b0, 5'h1C, 0); check("unmapped", rd, 0);
    cfg_wr(bif_pkg::REG_CFG, 32'h000A_5210);
    $display("test registers done");
    press(1'b1, 1'b1, 4'h0, 1'b1); check("actuated", 32'(actuated), 1);
    press(1'b0, 1'b1, 4'h0, 1'b0); check("actuated", 32'(actuated), 0);
    $display("test edges done");
    cfg_wr(bif_pkg::REG_CTRL, 32'h0000_0002);
    press(1'b1, 1'b1, 4'h0, 1'b0); check("actuated open", 32'(actuated), 0);
    press(1'b0, 1'b1, 4'h0, 1'b1); check("released open", 32'(actuated), 1);
    cfg_wr(bif_pkg::REG_CTRL, 32'h0000_0000);
    press(1'b1, 1'b1, 4'h0, 1'b1);
    press(1'b0, 1'b1, 4'h0, 1'b0); check("released closed", 32'(actuated), 0);
    $display("test polarity done");
    cfg_wr(bif_pkg::REG_CTRL, 32'h0000_0001);
    cfg_wr(bif_pkg::REG_CMD, 32'h0000_0001);
    press(1'b1, 1'b0, 4'h0, 1'b0); check("blocked", 32'(actuated), 0);
    press(1'b0, 1'b0, 4'h0, 1'b0);
    q.push_back(5'h01);
    @(posedge clk_sys);
    manual_act <= 1'b1;
    manual_en  <= 1'b1;
    wait_ms(15);
    q.push_back(5'h00);
    manual_act <= 1'b0;
    wait_ms(15);
    manual_en <= 1'b0;
    wait_ms(15);
    cfg_wr(bif_pkg::REG_CMD, 32'h0000_0000);
    press(1'b1, 1'b1, 4'h0, 1'b1);
    cfg_wr(bif_pkg::REG_CYC, 32'h0000_0003);
    cfg_wr(bif_pkg::REG_CMD, 32'h0000_0001);
    strict = 1'b0;
    bus(1'b1, bif_pkg::REG_CTRL, 32'h0000_0021);
    press(1'b0, 1'b0, 4'h0, 1'b0);
    cyc_cnt = 0;
    wait_ms(20);
    check("cyclic count", 32'(cyc_cnt >= 4), 1);
    check("cyclic value", 32'(last_val), 1);
    cfg_wr(bif_pkg::REG_CMD, 32'h0000_0000);
    cfg_wr(bif_pkg::REG_CTRL, 32'h0000_0000);
    $display("test blocking done");
    strict = 1'b0;
    lvl = 0;
    for (int i = 0; i < 16; i++) begin
      e[0] = (i < 6) ? 1'b1 : 1'($urandom % 2);
      bus(1'b1, bif_pkg::REG_CMD, {29'h0, 1'b1, e[0], 1'b0});
      repeat (4) @(posedge clk_sys);
      lvl = e[0] ? (lvl < 5 ? lvl + 1 : 5) : (lvl > 0 ? lvl - 1 : 0);
      check("level_byte", 32'(level_byte), 32'(lvl));
      check("level_bits", 32'(level_bits), (32'h1 << lvl) - 1);
    end
    wait_ms(15);
    q.delete();
    strict = 1'b1;
    $display("test sequence done");
    cfg_wr(bif_pkg::REG_TIME, 32'h0064_001E);
    cfg_wr(bif_pkg::REG_CTRL, 32'h0000_0014);
    for (int k = 0; k < 3; k++) begin
      q.push_back(k == 0 ? 5'h07 : (k == 1 ? 5'h05 : 5'h06));
      repeat (k == 0 ? 5 : (k == 1 ? 2 : 3)) begin
        press(1'b1, 1'b0, 4'h0, 1'b0);
        press(1'b0, 1'b0, 4'h0, 1'b0);
      end
      wait_ms(40);
    end
    press(1'b1, 1'b0, 4'h0, 1'b0);
    press(1'b0, 1'b0, 4'h0, 1'b0);
    press(1'b1, 1'b1, 4'h5, 1'b1);
    wait_ms(105);
    press(1'b0, 1'b0, 4'h0, 1'b0);
    wait_ms(40);
    // Send on every press: object goes out at once, nothing at gap expiry
    cfg_wr(bif_pkg::REG_CTRL, 32'h0000_001C);
    press(1'b1, 1'b1, 4'h1, 1'b1);
    press(1'b0, 1'b0, 4'h0, 1'b0);
    wait_ms(40);
    check("queue empty", 32'(q.size()), 0);
    $display("test multiple done");
    end_of_test();
  end
endmodule
